// ==== core/adc_range_and_alarm_regs.sv ====
// Purpose: Range configuration and alarm status registers on AHB-Lite
// Assumes: Comparator results valid when conv_done pulses
// Notes: Reads take one wait state, writes none
//   0x10 output control, 0x14 range, 0x20 alarm status
//   0x30 interrupt status (write one to clear), 0x34 interrupt mask
//   Non-word writes and unmapped offsets are ignored, reads return zero
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module adc_range_and_alarm_regs
	import adc_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic conv_done,
	input wire alarm_set_t cmp_alarm,
	output logic internal_ref_off,
	output logic [3:0] range_sel,
	output logic [1:0] append_input_live_flags,
	output logic [1:0] frame_alarm_bits,
	output logic irq
);
	// ==========================================================
	// Helpers
	function automatic logic range_code_ok(input logic [3:0] code);
		unique case (code)
			RNG_BI_3P0, RNG_BI_2P5, RNG_BI_1P5, RNG_BI_1P25, RNG_BI_0P625,
			RNG_UNI_3P0, RNG_UNI_2P5, RNG_UNI_1P5, RNG_UNI_1P25: range_code_ok = 1'b1;
			default: range_code_ok = 1'b0;
		endcase
	endfunction

	function automatic logic [3:0] flags_vec(input alarm_set_t a);
		flags_vec = {a.supply_low, a.supply_high, a.input_low, a.input_high};
	endfunction

	// Data-phase strobe aimed at one register offset
	function automatic logic reg_hit(input logic strobe, input logic [ADDR_W-1:0] addr,
			input logic [ADDR_W-1:0] ofs);
		reg_hit = strobe && (addr == ofs);
	endfunction

	// ==========================================================
	// Bus state
	logic wr_pend_q;
	logic rd_pend_q;
	logic [ADDR_W-1:0] addr_q;
	logic ref_off_q;
	logic [3:0] range_q;
	logic [1:0] append_q;
	alarm_set_t live_q;
	alarm_set_t latched_q;
	alarm_set_t latched_d;
	logic [3:0] irq_stat_q;
	logic [3:0] irq_mask_q;
	logic [31:0] status_word;
	logic [31:0] rd_word;
	logic take;
	logic wr_go;
	logic rd_go;
	logic [3:0] new_latch;
	logic [3:0] irq_stat_d;
	logic wr_range;
	logic wr_out_ctl;
	logic wr_irq_stat;
	logic wr_irq_mask;
	logic rd_alarm;
	logic wr_ref_off;
	logic [3:0] wr_range_code;
	logic [1:0] wr_append;
	logic [3:0] wr_irq_bits;

	assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign wr_go = wr_pend_q;
	assign rd_go = rd_pend_q && !hreadyout;

	// ==========================================================
	// Address decode and write fields
	assign wr_range = reg_hit(wr_go, addr_q, OFS_RANGE);
	assign wr_out_ctl = reg_hit(wr_go, addr_q, OFS_OUT_CTL);
	assign wr_irq_stat = reg_hit(wr_go, addr_q, OFS_IRQ_STAT);
	assign wr_irq_mask = reg_hit(wr_go, addr_q, OFS_IRQ_MASK);
	assign rd_alarm = reg_hit(rd_go, addr_q, OFS_ALARM);
	assign wr_ref_off = hwdata[REF_OFF_BIT];
	assign wr_range_code = hwdata[RNG_SEL_LSB +: 4];
	assign wr_append = hwdata[APPEND_LSB +: 2];
	assign wr_irq_bits = hwdata[3:0];

	// ==========================================================
	// Transfer capture
	// Write strobe for the data phase, word writes only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wr_pend_q <= 1'b0;
		else if (take)
			wr_pend_q <= hwrite && (hsize == HSIZE_WORD);
		else
			wr_pend_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rd_pend_q <= 1'b0;
		else if (take)
			rd_pend_q <= !hwrite;
		else if (rd_go)
			rd_pend_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			addr_q <= '0;
		else if (take)
			addr_q <= haddr[ADDR_W-1:0];
	end

	// ==========================================================
	// Bus responses
	// One wait state on reads so a preceding write has landed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hreadyout <= 1'b1;
		else if (take && !hwrite)
			hreadyout <= 1'b0;
		else
			hreadyout <= 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	// ==========================================================
	// Range and output control configuration
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ref_off_q <= REF_OFF_RST;
		else if (wr_range)
			ref_off_q <= wr_ref_off;
	end

	// Unlisted codes leave the converter on its last valid range
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			range_q <= RANGE_RST;
		else if (wr_range && range_code_ok(wr_range_code))
			range_q <= wr_range_code;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			append_q <= APPEND_RST;
		else if (wr_out_ctl)
			append_q <= wr_append;
	end

	// ==========================================================
	// Alarm flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			live_q <= ALARM_RST;
		else if (conv_done)
			live_q <= cmp_alarm;
	end

	// Set wins over clear-on-read
	always_comb begin
		latched_d = latched_q;
		if (rd_alarm)
			latched_d = ALARM_RST;
		if (conv_done)
			latched_d = alarm_set_t'(flags_vec(latched_d) | flags_vec(cmp_alarm));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			latched_q <= ALARM_RST;
		else
			latched_q <= latched_d;
	end

	assign new_latch = flags_vec(latched_d) & ~flags_vec(latched_q);

	// ==========================================================
	// Interrupts
	// Set wins over a write-one-to-clear in the same cycle
	always_comb begin
		irq_stat_d = irq_stat_q;
		if (wr_irq_stat)
			irq_stat_d = irq_stat_q & ~wr_irq_bits;
		irq_stat_d = irq_stat_d | new_latch;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq_stat_q <= IRQ_RST;
		else
			irq_stat_q <= irq_stat_d;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq_mask_q <= IRQ_RST;
		else if (wr_irq_mask)
			irq_mask_q <= wr_irq_bits;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_q & irq_mask_q);
	end

	// ==========================================================
	// Read path
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ACT_SUP_LOW_BIT] = live_q.supply_low;
		status_word[ACT_SUP_HIGH_BIT] = live_q.supply_high;
		status_word[ACT_IN_LOW_BIT] = live_q.input_low;
		status_word[ACT_IN_HIGH_BIT] = live_q.input_high;
		status_word[LAT_SUP_LOW_BIT] = latched_q.supply_low;
		status_word[LAT_SUP_HIGH_BIT] = latched_q.supply_high;
		status_word[LAT_IN_LOW_BIT] = latched_q.input_low;
		status_word[LAT_IN_HIGH_BIT] = latched_q.input_high;
		status_word[ANY_LAT_BIT] = |flags_vec(latched_q);
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (addr_q)
			OFS_RANGE: begin
				rd_word[REF_OFF_BIT] = ref_off_q;
				rd_word[RNG_SEL_LSB +: 4] = range_q;
			end
			OFS_OUT_CTL: rd_word[APPEND_LSB +: 2] = append_q;
			OFS_ALARM: rd_word = status_word;
			OFS_IRQ_STAT: rd_word[3:0] = irq_stat_q;
			OFS_IRQ_MASK: rd_word[3:0] = irq_mask_q;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hrdata <= 32'h0000_0000;
		else if (rd_go)
			hrdata <= rd_word;
	end

	// ==========================================================
	// Converter-facing outputs
	// Registered copies so every output leaves a flip-flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			internal_ref_off <= REF_OFF_RST;
			range_sel <= RANGE_RST;
		end else begin
			internal_ref_off <= ref_off_q;
			range_sel <= range_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			append_input_live_flags <= APPEND_RST;
		else
			append_input_live_flags <= append_q;
	end

	// Live input flags gated by the append selection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			frame_alarm_bits <= 2'h0;
		else
			frame_alarm_bits <= append_q & {live_q.input_low, live_q.input_high};
	end
endmodule

// ==== core/adc_regs_pkg.sv ====
// Purpose: Shared constants and types for the ADC range and alarm register bank
// Assumes: AHB-Lite slave, 32-bit words, byte addresses
// Notes: Offsets are byte addresses of aligned words
package adc_regs_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_OUT_CTL = 8'h10;
	localparam logic [7:0] OFS_RANGE = 8'h14;
	localparam logic [7:0] OFS_ALARM = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
	localparam int ADDR_W = 8;

	// ==========================================================
	// Range configuration fields
	localparam int RNG_SEL_LSB = 0;
	localparam int REF_OFF_BIT = 6;
	localparam logic [3:0] RANGE_RST = 4'h0;
	localparam logic REF_OFF_RST = 1'b0;

	// Range select codes
	localparam logic [3:0] RNG_BI_3P0 = 4'h0;
	localparam logic [3:0] RNG_BI_2P5 = 4'h1;
	localparam logic [3:0] RNG_BI_1P5 = 4'h2;
	localparam logic [3:0] RNG_BI_1P25 = 4'h3;
	localparam logic [3:0] RNG_BI_0P625 = 4'h4;
	localparam logic [3:0] RNG_UNI_3P0 = 4'h8;
	localparam logic [3:0] RNG_UNI_2P5 = 4'h9;
	localparam logic [3:0] RNG_UNI_1P5 = 4'hA;
	localparam logic [3:0] RNG_UNI_1P25 = 4'hB;

	// ==========================================================
	// Alarm status fields
	localparam int ACT_SUP_LOW_BIT = 15;
	localparam int ACT_SUP_HIGH_BIT = 14;
	localparam int ACT_IN_LOW_BIT = 11;
	localparam int ACT_IN_HIGH_BIT = 10;
	localparam int LAT_SUP_LOW_BIT = 7;
	localparam int LAT_SUP_HIGH_BIT = 6;
	localparam int LAT_IN_LOW_BIT = 5;
	localparam int LAT_IN_HIGH_BIT = 4;
	localparam int ANY_LAT_BIT = 0;

	// Output control field
	localparam int APPEND_LSB = 10;
	localparam logic [1:0] APPEND_RST = 2'h0;

	// Interrupt registers, one bit per latched alarm
	localparam logic [3:0] IRQ_RST = 4'h0;

	// ==========================================================
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// One alarm flag set
	typedef struct packed {
		logic supply_low;
		logic supply_high;
		logic input_low;
		logic input_high;
	} alarm_set_t;

	localparam alarm_set_t ALARM_RST = '0;
endpackage

// ==== verification/regs_props.sv ====
// Purpose: Bus timing and alarm output checks
// Assumes: One wait state per read, none per write
// Notes: Bound to the register bank
`timescale 1ns/1ps
module regs_props
	import adc_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic conv_done,
	input wire alarm_set_t cmp_alarm,
	input wire logic irq,
	input wire logic [3:0] range_sel,
	input wire logic internal_ref_off,
	input wire logic [1:0] append_input_live_flags,
	input wire logic [1:0] frame_alarm_bits
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic go;
	assign go = hsel && hready && htrans == HTRANS_NONSEQ;
	sequence read_wait_s;
		!hreadyout ##1 hreadyout;
	endsequence
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	chk_read_wait: assert property (go && !hwrite |=> read_wait_s)
		else $error("read wait wrong");
	chk_write_nowait: assert property (go && hwrite |=> hreadyout)
		else $error("write stalled");
	chk_range_legal: assert property (range_sel inside {[4'h0:4'h4], [4'h8:4'hB]})
		else $error("range code illegal");
	chk_range_cause: assert property ($changed(range_sel) |-> $past(go && hwrite, 3))
		else $error("range changed without write");
	chk_ref_cause: assert property ($changed(internal_ref_off) |-> $past(go && hwrite, 3))
		else $error("reference control changed without write");
	chk_irq_rise: assert property ($rose(irq) |-> $past(conv_done, 2) || $past(go && hwrite, 3))
		else $error("irq rose without cause");
	chk_irq_fall: assert property ($fell(irq) |-> $past(go && hwrite, 3))
		else $error("irq fell without write");
	chk_frame_gate: assert property ((frame_alarm_bits & ~append_input_live_flags) == 2'b00)
		else $error("frame flag not enabled");
	chk_frame_follow: assert property (conv_done |-> ##2 (frame_alarm_bits ==
		(append_input_live_flags &
		{$past(cmp_alarm.input_low, 2), $past(cmp_alarm.input_high, 2)})))
		else $error("frame flags do not follow comparator");
endmodule
bind adc_range_and_alarm_regs regs_props i_props (
	.clk(clk),
	.rst_n(rst_n),
	.hsel(hsel),
	.htrans(htrans),
	.hwrite(hwrite),
	.hready(hready),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.conv_done(conv_done),
	.cmp_alarm(cmp_alarm),
	.irq(irq),
	.range_sel(range_sel),
	.internal_ref_off(internal_ref_off),
	.append_input_live_flags(append_input_live_flags),
	.frame_alarm_bits(frame_alarm_bits)
);

// ==== verification/alarm_source.sv ====
// Purpose: Comparator side that reports alarm results
// Assumes: Results only meaningful with conv_done
// Notes: Result lines toggle between conversions
`timescale 1ns/1ps
module alarm_source
	import adc_regs_pkg::*;
(
	input wire logic clk,
	input wire logic go,
	input wire alarm_set_t val,
	output logic conv_done,
	output alarm_set_t cmp_alarm
);
	initial begin
		conv_done = 1'b0;
		cmp_alarm = ALARM_RST;
	end
	always @(posedge clk) begin
		conv_done <= go;
		cmp_alarm <= go ? val : ~cmp_alarm;
	end
endmodule

// ==== verification/tb_adc_range_and_alarm_regs.sv ====
// Purpose: Register and alarm tests over the bus
// Assumes: Single transfers, all word sized except one byte write
// Notes: Expected values built from field positions
`timescale 1ns/1ps
module tb_adc_range_and_alarm_regs
	import adc_regs_pkg::*;
;
	logic clk, rst_n, hsel, hwrite, hreadyout, hresp, conv_done, go, internal_ref_off, irq;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, append_input_live_flags, frame_alarm_bits;
	logic [2:0] hsize;
	logic [3:0] range_sel;
	alarm_set_t cmp_alarm, val;
	int miscompares, cmp_count, cycles;
	logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB};
	adc_range_and_alarm_regs i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .conv_done(conv_done),
		.cmp_alarm(cmp_alarm), .internal_ref_off(internal_ref_off), .range_sel(range_sel),
		.append_input_live_flags(append_input_live_flags),
		.frame_alarm_bits(frame_alarm_bits), .irq(irq));
	alarm_source i_src (.clk(clk), .go(go), .val(val), .conv_done(conv_done),
		.cmp_alarm(cmp_alarm));
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		if (!w) chk(hrdata, e);
	endtask
	task pulse(input alarm_set_t v);
		go <= 1'b1;
		val <= v;
		@(posedge clk);
		go <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task complete_run;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		{rst_n, hsel, hwrite, go, htrans, haddr, hwdata} = '0;
		hsize = HSIZE_WORD;
		val = ALARM_RST;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		xfer(0, OFS_RANGE, 0, 32'h0000_0000);
		xfer(0, OFS_ALARM, 0, 32'h0000_0000);
		xfer(0, 8'h40, 0, 32'h0000_0000);
		xfer(1, OFS_ALARM, 32'hFFFF_FFFF, 0);
		xfer(0, OFS_ALARM, 0, 32'h0000_0000);
		hsize <= 3'h0;
		xfer(1, OFS_RANGE, 32'h0000_0049, 0);
		hsize <= HSIZE_WORD;
		xfer(0, OFS_RANGE, 0, 32'h0000_0000);
		$display("test reset done");
		foreach (codes[i]) begin
			xfer(1, OFS_RANGE, 32'hFFFF_FFF0 | codes[i], 0);
			xfer(0, OFS_RANGE, 0, 32'h0000_0040 | codes[i]);
			chk({27'h0, internal_ref_off, range_sel}, {27'h0, 1'b1, codes[i]});
		end
		xfer(1, OFS_RANGE, 32'h0000_0005, 0);
		xfer(0, OFS_RANGE, 0, 32'h0000_000B);
		$display("test range done");
		pulse(4'b1001);
		chk({31'h0, irq}, 0);
		xfer(1, OFS_IRQ_MASK, 32'h0000_000F, 0);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 1);
		xfer(1, OFS_IRQ_STAT, 32'h0000_000F, 0);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 0);
		xfer(0, OFS_ALARM, 0, 32'h0000_8491);
		pulse(4'b0110);
		xfer(0, OFS_ALARM, 0, 32'h0000_4861);
		xfer(0, OFS_ALARM, 0, 32'h0000_4800);
		pulse(4'b0000);
		xfer(0, OFS_ALARM, 0, 32'h0000_0000);
		$display("test alarm done");
		for (int c = 0; c < 4; c++) begin
			xfer(1, OFS_OUT_CTL, {20'h0, c[1:0], 10'h0}, 0);
			pulse(4'b0011);
			chk({30'h0, frame_alarm_bits}, c);
			chk({30'h0, append_input_live_flags}, c);
		end
		$display("test frame done");
		complete_run();
	end
endmodule
